// ==== design/rsm_cfg.svh ====
// timing and layout constants for the repeat string move sequencer
// assumes costs are given directly in core clock cycles
`ifndef RSM_CFG_SVH
`define RSM_CFG_SVH

`define RSM_BYTE_SMALL_LIM 32'h4
`define RSM_T_BYTE_SMALL 8'h9
`define RSM_T_BYTE_START 8'h32
`define RSM_SHORT_MAX 32'hc
`define RSM_T_SHORT 8'h14
`define RSM_FAST_MIN 32'h4c
`define RSM_T_FAST 8'h28
`define RSM_T_FAST_SPLIT 8'h23
`define RSM_T_MID 8'hf
`define RSM_PIECE_BYTES 32'h10
`define RSM_PIECE_OFS_MSB 3
`define RSM_PIECES_PER_LINE 2'h3
`define RSM_SPLIT_EXTRA 8'h2
`define RSM_FIFO_DEPTH 16
`define RSM_XFER_W 67

`endif

// ==== design/rsm_fifo.sv ====
// descriptor fifo with a registered output stage
// assumes a single clock; depth is a power of two
module rsm_fifo #(
    parameter int W = 67,
    parameter int D = 16
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] DEPTH_P = (AW+1)'(D);

    logic [W-1:0] mem [D];
    logic [AW:0] wptr_reg, wptr_next;
    logic [AW:0] rptr_reg, rptr_next;
    logic out_valid_reg, out_valid_next;
    logic [W-1:0] out_data_reg, out_data_next;
    logic push, load_out;

    always_comb begin
        in_ready_o = (wptr_reg - rptr_reg) != DEPTH_P;
        push = in_valid_i && in_ready_o;
        load_out = (wptr_reg != rptr_reg) && (!out_valid_reg || out_ready_i);
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = load_out ? rptr_reg + 1'b1 : rptr_reg;
        out_data_next = load_out ? mem[rptr_reg[AW-1:0]] : out_data_reg;
        if (load_out) begin
            out_valid_next = 1'b1;
        end else if (out_ready_i) begin
            out_valid_next = 1'b0;
        end else begin
            out_valid_next = out_valid_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
        end
    end

    assign out_valid_o = out_valid_reg;
    assign out_data_o = out_data_reg;
endmodule // rsm_fifo

// ==== design/rsm_pkg.sv ====
// types for the repeat string move sequencer
// assumes rsm_cfg.svh is available on the include path
package rsm_pkg;

    typedef enum logic [1:0] {
        RSM_G_BYTE = 2'h0,
        RSM_G_WORD = 2'h1,
        RSM_G_DWORD = 2'h2,
        RSM_G_QWORD = 2'h3
    } rsm_gran_t;

    typedef enum logic [2:0] {
        RSM_S_IDLE = 3'h1,
        RSM_S_START = 3'h2,
        RSM_S_RUN = 3'h4
    } rsm_state_t;

endpackage

// ==== design/rsm_seq.sv ====
// repeat string move / store sequencer with latency model
// assumes the command comes from logic on MCLK_I and addresses ascend
//
// Summary of operation
// - each iteration moves one byte/word/dword/qword element
// - small byte moves finish in nine cycles
// - byte moves above nine pay fifty-cycle startup
// - short wide moves take about twenty cycles
// - long wide moves use sixteen-byte pieces
// - split-free fast mode: 40 plus 4/64B
// - split fast mode: 35 plus 6/64B
// - intermediate wide moves: fifteen plus one/element
// - fast mode allowed for unaligned addresses
`include "rsm_cfg.svh"
module rsm_seq
    import rsm_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic START_I,
    input wire logic STORE_I,
    input wire logic [1:0] GRAN_I,
    input wire logic [31:0] COUNT_I,
    input wire logic [31:0] SRC_I,
    input wire logic [31:0] DST_I,
    output logic BUSY_O,
    output logic DONE_O,
    output logic FAST_O,
    output logic SPLIT_O,
    output logic [31:0] REMAIN_O,
    output logic XFER_VALID_O,
    input wire logic XFER_READY_I,
    output logic XFER_PIECE_O,
    output logic [1:0] XFER_SIZE_O,
    output logic [31:0] XFER_SRC_O,
    output logic [31:0] XFER_DST_O
);
    function automatic logic [31:0] elem_bytes(input logic [1:0] g);
        elem_bytes = 32'h1 << g;
    endfunction

    function automatic logic [31:0] elem_per_piece(input logic [1:0] g);
        elem_per_piece = `RSM_PIECE_BYTES >> g;
    endfunction

    rsm_state_t state_reg, state_next;
    logic [31:0] remain_reg, remain_next;
    logic [31:0] src_reg, src_next;
    logic [31:0] dst_reg, dst_next;
    logic [1:0] gran_reg, gran_next;
    logic fast_reg, fast_next;
    logic split_reg, split_next;
    logic store_reg, store_next;
    logic [7:0] wait_reg, wait_next;
    logic [1:0] piece_cnt_reg, piece_cnt_next;
    logic done_reg, done_next;
    logic in_valid, in_ready;
    logic in_piece;
    logic [`RSM_XFER_W-1:0] in_data, out_data;
    logic go_fast, go_split;
    logic [7:0] startup;
    logic [31:0] step;

    // mode and startup cost chosen once at entry
    always_comb begin
        go_fast = (GRAN_I != RSM_G_BYTE) && (COUNT_I >= `RSM_FAST_MIN);
        // pieces keep the start offset, so a misaligned start splits some line
        go_split = go_fast && ((DST_I[`RSM_PIECE_OFS_MSB:0] != 4'h0) ||
            (!STORE_I && (SRC_I[`RSM_PIECE_OFS_MSB:0] != 4'h0)));
        if (GRAN_I == RSM_G_BYTE) begin
            if (COUNT_I < `RSM_BYTE_SMALL_LIM) begin
                startup = `RSM_T_BYTE_SMALL - COUNT_I[7:0];
            end else begin
                // counts four to nine also take the long byte startup
                startup = `RSM_T_BYTE_START;
            end
        end else if (COUNT_I <= `RSM_SHORT_MAX) begin
            startup = `RSM_T_SHORT - COUNT_I[7:0];
        end else if (go_split) begin
            startup = `RSM_T_FAST_SPLIT;
        end else if (go_fast) begin
            startup = `RSM_T_FAST;
        end else begin
            startup = `RSM_T_MID;
        end
    end

    always_comb begin
        state_next = state_reg;
        remain_next = remain_reg;
        src_next = src_reg;
        dst_next = dst_reg;
        gran_next = gran_reg;
        fast_next = fast_reg;
        split_next = split_reg;
        store_next = store_reg;
        wait_next = wait_reg;
        piece_cnt_next = piece_cnt_reg;
        done_next = 1'b0;
        in_valid = 1'b0;
        in_piece = fast_reg && (remain_reg >= elem_per_piece(gran_reg));
        step = in_piece ? `RSM_PIECE_BYTES : elem_bytes(gran_reg);
        case (state_reg)
            RSM_S_IDLE: begin
                if (START_I) begin
                    if (COUNT_I == 32'h0) begin
                        done_next = 1'b1;
                    end else begin
                        remain_next = COUNT_I;
                        src_next = SRC_I;
                        dst_next = DST_I;
                        gran_next = GRAN_I;
                        store_next = STORE_I;
                        fast_next = go_fast;
                        split_next = go_split;
                        // the first push itself uses the last startup cycle
                        wait_next = startup - 8'h1;
                        piece_cnt_next = 2'h0;
                        state_next = RSM_S_START;
                    end
                end
            end
            RSM_S_START: begin
                if (wait_reg > 8'h1) begin
                    wait_next = wait_reg - 8'h1;
                end else begin
                    wait_next = 8'h0;
                    state_next = RSM_S_RUN;
                end
            end
            RSM_S_RUN: begin
                if (wait_reg != 8'h0) begin
                    wait_next = wait_reg - 8'h1;
                end else begin
                    // a full fifo stalls issue; the cost model then stretches
                    in_valid = 1'b1;
                    if (in_ready) begin
                        src_next = src_reg + step;
                        dst_next = dst_reg + step;
                        if (in_piece) begin
                            remain_next = remain_reg - elem_per_piece(gran_reg);
                            piece_cnt_next = piece_cnt_reg + 2'h1;
                            // split path: 4 pieces cost 6 cycles, so 2 idle per 64B
                            if (split_reg && piece_cnt_reg == `RSM_PIECES_PER_LINE) begin
                                wait_next = `RSM_SPLIT_EXTRA;
                            end
                        end else begin
                            remain_next = remain_reg - 32'h1;
                        end
                        if (remain_next == 32'h0) begin
                            done_next = 1'b1;
                            state_next = RSM_S_IDLE;
                        end
                    end
                end
            end
            default: begin
                state_next = RSM_S_IDLE;
            end
        endcase
        in_data = {in_piece, gran_reg, store_reg ? 32'h0 : src_reg, dst_reg};
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_reg <= RSM_S_IDLE;
            remain_reg <= 32'h0;
            src_reg <= 32'h0;
            dst_reg <= 32'h0;
            gran_reg <= 2'h0;
            fast_reg <= 1'b0;
            split_reg <= 1'b0;
            store_reg <= 1'b0;
            wait_reg <= 8'h0;
            piece_cnt_reg <= 2'h0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            remain_reg <= remain_next;
            src_reg <= src_next;
            dst_reg <= dst_next;
            gran_reg <= gran_next;
            fast_reg <= fast_next;
            split_reg <= split_next;
            store_reg <= store_next;
            wait_reg <= wait_next;
            piece_cnt_reg <= piece_cnt_next;
            done_reg <= done_next;
        end
    end

    rsm_fifo #(
        .W(`RSM_XFER_W),
        .D(`RSM_FIFO_DEPTH)
    ) u_fifo (
        .clk_i(MCLK_I),
        .arst_n_i(ARST_N_I),
        .in_valid_i(in_valid),
        .in_ready_o(in_ready),
        .in_data_i(in_data),
        .out_valid_o(XFER_VALID_O),
        .out_ready_i(XFER_READY_I),
        .out_data_o(out_data)
    );

    assign BUSY_O = state_reg != RSM_S_IDLE;
    assign DONE_O = done_reg;
    assign FAST_O = fast_reg;
    assign SPLIT_O = split_reg;
    assign REMAIN_O = remain_reg;
    assign XFER_PIECE_O = out_data[66];
    assign XFER_SIZE_O = out_data[65:64];
    assign XFER_SRC_O = out_data[63:32];
    assign XFER_DST_O = out_data[31:0];
endmodule // rsm_seq

// ==== verification/rsm_seq_bench.sv ====
// self-checking bench for the repeat string move sequencer
// assumes the fifo drains within 24 cycles once the sink is ready
module rsm_seq_bench;
    import rsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK_I = 1'b0;
    logic ARST_N_I, START_I, STORE_I, XFER_READY_I, hold;
    logic [1:0] GRAN_I;
    logic [31:0] COUNT_I, SRC_I, DST_I;
    logic BUSY_O, DONE_O, FAST_O, SPLIT_O, XFER_VALID_O, XFER_PIECE_O;
    logic [1:0] XFER_SIZE_O;
    logic [31:0] REMAIN_O, XFER_SRC_O, XFER_DST_O;
    logic [66:0] last;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int taken, n, k;
    rsm_seq DUT (.*);
    rsm_sink u_sink (.clk_i(MCLK_I), .arst_n_i(ARST_N_I), .valid_i(XFER_VALID_O),
        .hold_i(hold), .desc_i({XFER_PIECE_O, XFER_SIZE_O, XFER_SRC_O, XFER_DST_O}),
        .ready_o(XFER_READY_I), .n_taken_o(taken), .last_o(last));
    always #2 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // returns edges from the taking edge to done, and descriptors taken
    task run(input logic [1:0] g, input logic [31:0] c, input logic [31:0] d, input logic st);
        int base;
        base = taken;
        @(negedge MCLK_I);
        {GRAN_I, COUNT_I, DST_I, SRC_I, STORE_I, START_I} = {g, c, d, d + 32'h100, st, 1'b1};
        @(negedge MCLK_I);
        START_I = 1'b0;
        n = 1;
        while (DONE_O !== 1'b1 && n < 400) begin
            @(posedge MCLK_I);
            #1 n++;
        end
        repeat (24) @(posedge MCLK_I);
        #1 k = taken - base;
    endtask
    task t_zero;
        run(RSM_G_WORD, 32'h0, 32'h0, 1'b0);
        check(n, 1);
        check(k, 0);
    endtask
    task t_byte;
        run(RSM_G_BYTE, 32'h3, 32'h7, 1'b1);
        check(n, 9);
        check(k, 3);
        check(last[66:64], 32'h0);
        check(last[63:32], 32'h0);
        check(last[31:0], 32'h9);
        run(RSM_G_BYTE, 32'ha, 32'h0, 1'b0);
        check(n, 60);
        check(k, 10);
    endtask
    task t_wide;
        run(RSM_G_WORD, 32'hc, 32'h0, 1'b0);
        check(n, 20);
        run(RSM_G_DWORD, 32'h14, 32'h0, 1'b1);
        check(n, 35);
        check(k, 20);
        check(last[31:0], 32'h4c);
    endtask
    task t_fast;
        run(RSM_G_QWORD, 32'h50, 32'h40, 1'b0);
        check(n, 80);
        check({FAST_O, SPLIT_O}, 2'h2);
        check(k, 40);
        check(last[66:64], 32'h7);
        check(last[63:32], 32'h3b0);
        check(last[31:0], 32'h2b0);
        run(RSM_G_WORD, 32'h4c, 32'h0, 1'b1);
        check(k, 13);
        check(last[66:64], 32'h1);
        check(last[31:0], 32'h96);
        check(n, 53);
    endtask
    task t_split;
        run(RSM_G_QWORD, 32'h4e, 32'h4, 1'b0);
        check(n, 92);
        check({FAST_O, SPLIT_O}, 2'h3);
        check(k, 39);
        check(last[63:32], 32'h364);
        check(last[31:0], 32'h264);
    endtask
    // sink stalls long enough for the fifo to refuse and hold the sequencer
    task t_stall;
        hold = 1'b1;
        fork
            run(RSM_G_DWORD, 32'h28, 32'h0, 1'b0);
            begin
                repeat (60) @(posedge MCLK_I);
                #1 check(BUSY_O, 1);
                check(REMAIN_O, 32'd23);
                @(negedge MCLK_I);
                hold = 1'b0;
            end
        join
        check(k, 40);
        check(REMAIN_O, 32'h0);
        check(last[66:64], 32'h2);
        check(last[31:0], 32'h9c);
    endtask
    initial begin
        {ARST_N_I, START_I, STORE_I, GRAN_I, COUNT_I, SRC_I, DST_I, hold} = '0;
        repeat (3) @(posedge MCLK_I);
        @(negedge MCLK_I);
        ARST_N_I = 1'b1;
        t_zero();
        t_byte();
        t_wide();
        t_fast();
        t_split();
        t_stall();
        stop_test();
    end
endmodule // rsm_seq_bench

// ==== verification/rsm_seq_sva.sv ====
// port assertions for the repeat string move sequencer
// assumes a prompt descriptor sink and an empty fifo at each command
module rsm_seq_sva (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic START_I,
    input wire logic [1:0] GRAN_I,
    input wire logic [31:0] COUNT_I,
    input wire logic [31:0] DST_I,
    input wire logic BUSY_O,
    input wire logic DONE_O,
    input wire logic FAST_O,
    input wire logic SPLIT_O,
    input wire logic [31:0] REMAIN_O,
    input wire logic XFER_VALID_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    logic go;
    logic wide;
    assign go = START_I && !BUSY_O;
    assign wide = GRAN_I != 2'h0;
    property p_zero; go && COUNT_I == 32'h0 |=> DONE_O && !BUSY_O; endproperty
    a_zero: assert property (p_zero) else $error("zero count not done at once");
    property p_busy; go && COUNT_I != 32'h0 |=> BUSY_O && !DONE_O; endproperty
    a_busy: assert property (p_busy) else $error("busy missing after start");
    property p_bsmall; go && !wide && COUNT_I != 32'h0 && COUNT_I < 32'h4 |-> ##9 DONE_O; endproperty
    a_bsmall: assert property (p_bsmall) else $error("small byte latency wrong");
    property p_blong; go && !wide && COUNT_I > 32'h9 |-> ##51 !XFER_VALID_O ##1 XFER_VALID_O;
    endproperty
    a_blong: assert property (p_blong) else $error("byte startup wrong");
    property p_short; go && wide && COUNT_I != 32'h0 && COUNT_I <= 32'hc |-> ##20 DONE_O; endproperty
    a_short: assert property (p_short) else $error("short wide latency wrong");
    property p_mid; go && wide && COUNT_I >= 32'hd && COUNT_I <= 32'h4b
        |-> ##16 !XFER_VALID_O ##1 XFER_VALID_O; endproperty
    a_mid: assert property (p_mid) else $error("mid startup wrong");
    property p_fast; go && wide && COUNT_I >= 32'h4c |-> ##2 FAST_O; endproperty
    a_fast: assert property (p_fast) else $error("fast mode not entered");
    property p_split; go && wide && COUNT_I >= 32'h4c && DST_I[3:0] != 4'h0 |-> ##2 SPLIT_O;
    endproperty
    a_split: assert property (p_split) else $error("split cost not chosen");
    property p_remain; DONE_O |-> REMAIN_O == 32'h0; endproperty
    a_remain: assert property (p_remain) else $error("count left at done");
endmodule // rsm_seq_sva
bind rsm_seq rsm_seq_sva u_sva (.*);

// ==== verification/rsm_sink.sv ====
// descriptor sink standing in for the cache and memory side
// assumes the bench stalls it through hold_i and reads the count
module rsm_sink (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic valid_i,
    input wire logic hold_i,
    input wire logic [66:0] desc_i,
    output logic ready_o,
    output int n_taken_o,
    output logic [66:0] last_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign ready_o = !hold_i;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            n_taken_o <= 0;
            last_o <= '0;
        end else if (valid_i && ready_o) begin
            n_taken_o <= n_taken_o + 1;
            // last accepted descriptor lets the bench judge piece, size and addresses
            last_o <= desc_i;
        end
    end
endmodule // rsm_sink
